// ---- txck_params.svh ----
// timing, field positions, reset values and register offsets of the tx clock control block
// assumes inclusion by the block's design file and its testbench only
`ifndef TXCK_PARAMS_SVH
`define TXCK_PARAMS_SVH

`define TXCK_ADDR_CTRL 12'h000
`define TXCK_ADDR_RATE 12'h004
`define TXCK_ADDR_PPM 12'h008
`define TXCK_ADDR_OVRD 12'h00C
`define TXCK_ADDR_STAT 12'h010

// ctrl register fields
`define TXCK_CTRL_OUTSEL_LSB 0
`define TXCK_CTRL_PROGSRC_LSB 4
`define TXCK_CTRL_ASYNC_BIT 6
`define TXCK_CTRL_BUFRST_BIT 7
`define TXCK_CTRL_STATDIV_LSB 8
`define TXCK_CTRL_CLK25_LSB 16
// rate register fields
`define TXCK_RATE_SEL_LSB 0
`define TXCK_RATE_DELAY_LSB 8
// ppm register fields
`define TXCK_PPM_EN_BIT 0
`define TXCK_PPM_PD_BIT 1
`define TXCK_PPM_GRAY_BIT 2
`define TXCK_PPM_INTV_LSB 4
`define TXCK_PPM_STEP_LSB 8
// override register fields
`define TXCK_OVRD_CODE_LSB 0
`define TXCK_OVRD_EN_BIT 8

`define TXCK_RST_CTRL 32'h0004_0100
`define TXCK_RST_RATE 32'h0000_1000
`define TXCK_RST_PPM 32'h0000_0010
`define TXCK_RST_OVRD 32'h0000_0000
`define TXCK_RST_STATDIV 5'h01
`define TXCK_RST_CLK25 6'h04

// user clock 2 modelled as one cycle of the bus clock
`define TXCK_RATE_DELAY_UNIT_NS 10
`define TXCK_CLK_PERIOD_NS 10
`define TXCK_RATE_DELAY_CYC ((`TXCK_RATE_DELAY_UNIT_NS + `TXCK_CLK_PERIOD_NS - 1) / `TXCK_CLK_PERIOD_NS)

`endif

// ---- txck_pkg.sv ----
// types shared by the tx clock control block
// assumes txck_params.svh is on the include path
package txck_pkg;
  typedef enum logic [2:0] {
    TXCK_OUT_HIGH, TXCK_OUT_PCS, TXCK_OUT_PMA, TXCK_OUT_REF1, TXCK_OUT_REF2, TXCK_OUT_PROG
  } txck_outsel_e;
  typedef enum logic [1:0] {TXCK_SRC_AFTER_PI, TXCK_SRC_BEFORE_PI, TXCK_SRC_PLL} txck_src_e;
  typedef struct packed {
    logic pcs_clk_path;
    logic pma_clk_path;
    logic pll_ref_clk_undivided;
    logic pll_ref_clk_halved;
    logic prog_divider_clk;
  } txck_clks_s;
  typedef struct packed {
    logic [4:0] serial_div;
    logic buffer_reset;
    logic reset_seq;
  } txck_div_s;
  typedef logic [6:0] txck_pi_code_t;
endpackage

// ---- txck_top.sv ----
// tx clock output selection, serial divider, rate change timing and pi ppm controller
// assumes an apb master on pclk; clock sources arrive from other domains as plain pins
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "txck_params.svh"

// Overview of operation
// - three-bit select picks the user-facing clock: high, pcs, pma, ref, ref/2, prog.
// - rate code zero uses static divider; codes one to five give 1,2,4,8,16.
// - a rate change yields one done pulse after the programmed delay; a change while busy restarts the delay.
// - eight-bit transition delay sets when done and phy status assert.
// - sync mode runs a reset sequence per rate change; async mode applies directly.
// - buffer reset option resets the tx buffer during rate-triggered changes.
// - static divider applies at rate zero and at codes six and seven, and accepts 1,2,4,8,16 only.
// - programmable divider source is after-pi, before-pi or channel pll clock.
// - an internal low-rate clock paces the rate change delay timer.
// - reference is divided by an integer one to thirty-two for that clock.
// - ppm disabled holds the interpolator code; enabled updates it periodically.
// - code updates every interval plus one cycles; interval zero is invalid.
// - step bit four is direction, up when high; bits three to zero magnitude.
// - step magnitude is binary or gray coded per gray-select setting.
// - override drives code from low seven bits, latched on top-bit pulse.
// - power-down bit of the ppm register high powers down the ppm controller.
module txck_top import txck_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire txck_clks_s clk_pins,
  input wire logic after_interpolator_path,
  input wire logic before_interpolator_path,
  input wire logic channel_pll,
  input wire logic ppm_ctrl_select,
  input wire logic tx_delay_align_bypass,
  output logic tx_clk_out,
  output logic prog_divider_src_clk,
  output logic low_rate_clk_en,
  output txck_div_s div_out,
  output logic tx_rate_change_done,
  output logic phy_status,
  output txck_pi_code_t pi_code
);
  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [31:0] rate_reg;
  logic [31:0] ppm_reg;
  logic [31:0] ovrd_reg;
  logic [4:0] div_reg;
  logic [4:0] div_next;
  wire wr_en = psel & penable & pwrite;
  wire hit_ctrl = paddr == `TXCK_ADDR_CTRL;
  wire hit_rate = paddr == `TXCK_ADDR_RATE;
  wire hit_ppm = paddr == `TXCK_ADDR_PPM;
  wire hit_ovrd = paddr == `TXCK_ADDR_OVRD;
  wire hit_stat = paddr == `TXCK_ADDR_STAT;
  wire hit_any = hit_ctrl | hit_rate | hit_ppm | hit_ovrd | hit_stat;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  wire [2:0] out_select = ctrl_reg[`TXCK_CTRL_OUTSEL_LSB +: 3];
  wire [1:0] prog_src = ctrl_reg[`TXCK_CTRL_PROGSRC_LSB +: 2];
  wire tx_rate_async_mode = ctrl_reg[`TXCK_CTRL_ASYNC_BIT];
  wire buffer_reset_on_rate_change = ctrl_reg[`TXCK_CTRL_BUFRST_BIT];
  wire [4:0] wr_statdiv = pwdata[`TXCK_CTRL_STATDIV_LSB +: 5];
  wire [5:0] low_rate_clk_divider = ctrl_reg[`TXCK_CTRL_CLK25_LSB +: 6];
  wire [2:0] tx_rate_select = rate_reg[`TXCK_RATE_SEL_LSB +: 3];
  wire [7:0] rate_transition_delay = rate_reg[`TXCK_RATE_DELAY_LSB +: 8];
  wire ppm_ctrl_enable = ppm_reg[`TXCK_PPM_EN_BIT];
  wire ppm_ctrl_powerdown = ppm_reg[`TXCK_PPM_PD_BIT];
  wire step_gray_select = ppm_reg[`TXCK_PPM_GRAY_BIT];
  wire [2:0] pi_update_interval = ppm_reg[`TXCK_PPM_INTV_LSB +: 3];
  wire [4:0] pi_step_control = ppm_reg[`TXCK_PPM_STEP_LSB +: 5];
  wire [7:0] pi_override_code = ovrd_reg[`TXCK_OVRD_CODE_LSB +: 8];
  wire pi_code_override_enable = ovrd_reg[`TXCK_OVRD_EN_BIT];

  // static divider: only power-of-two values up to 16 are stored
  wire statdiv_ok = (wr_statdiv == 5'h01) | (wr_statdiv == 5'h02) | (wr_statdiv == 5'h04) |
                    (wr_statdiv == 5'h08) | (wr_statdiv == 5'h10);
  // divider source is a 2-bit code; 3 is not a legal source and is refused
  wire progsrc_ok = pwdata[`TXCK_CTRL_PROGSRC_LSB +: 2] != 2'h3;
  // low-rate divider accepted from 1 to 32
  wire [5:0] wr_clk25 = pwdata[`TXCK_CTRL_CLK25_LSB +: 6];
  wire clk25_ok = (wr_clk25 != 6'h00) & (wr_clk25 <= 6'h20);
  assign div_next = (wr_en & hit_ctrl & statdiv_ok) ? wr_statdiv : div_reg;

  wire [31:0] ctrl_wr = {10'h000, clk25_ok ? wr_clk25 : low_rate_clk_divider,
                         3'h0, div_next, pwdata[7:6],
                         progsrc_ok ? pwdata[5:4] : prog_src, 1'b0, pwdata[2:0]};

  // user straps come from another domain; two flops before any use
  logic [1:0] strap_s1;
  logic [1:0] strap_s2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_s1 <= 2'h0;
      strap_s2 <= 2'h0;
    end else begin
      strap_s1 <= {tx_delay_align_bypass, ppm_ctrl_select};
      strap_s2 <= strap_s1;
    end
  end
  wire ppm_select_sync = strap_s2[0];
  // bypass strap only reported, so software can see how the user set it
  wire delay_bypass_sync = strap_s2[1];

  logic rate_busy_reg;
  logic pi_latched_reg;
  txck_pi_code_t pi_code_reg;
  wire [31:0] stat_word = {20'h0, delay_bypass_sync, ppm_select_sync, rate_busy_reg,
                           pi_latched_reg, 1'b0, pi_code_reg};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `TXCK_RST_CTRL;
      rate_reg <= `TXCK_RST_RATE;
      ppm_reg <= `TXCK_RST_PPM;
      ovrd_reg <= `TXCK_RST_OVRD;
      div_reg <= `TXCK_RST_STATDIV;
    end else if (wr_en) begin
      div_reg <= div_next;
      if (hit_ctrl) ctrl_reg <= ctrl_wr;
      if (hit_rate) rate_reg <= {16'h0, pwdata[15:8], 5'h00, pwdata[2:0]};
      // an interval of zero is invalid and keeps the old interval
      if (hit_ppm) ppm_reg <= {19'h0, pwdata[12:8], 1'b0,
                               (pwdata[6:4] == 3'h0) ? pi_update_interval : pwdata[6:4],
                               1'b0, pwdata[2:0]};
      if (hit_ovrd) ovrd_reg <= {23'h0, pwdata[8:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite) begin
      prdata <= hit_ctrl ? ctrl_reg : hit_rate ? rate_reg : hit_ppm ? ppm_reg :
                hit_ovrd ? ovrd_reg : hit_stat ? stat_word : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // clock output selection
  // ----------------------------------------------------------------
  // glitch-free switching is left to the clock mux cell; this is a plain select
  logic [4:0] clk_s1;
  logic [4:0] clk_s2;
  logic [2:0] src_s1;
  logic [2:0] src_s2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_s1 <= 5'h00;
      clk_s2 <= 5'h00;
      src_s1 <= 3'h0;
      src_s2 <= 3'h0;
    end else begin
      clk_s1 <= clk_pins;
      clk_s2 <= clk_s1;
      src_s1 <= {channel_pll, before_interpolator_path, after_interpolator_path};
      src_s2 <= src_s1;
    end
  end
  txck_clks_s clks;
  assign clks = clk_s2;
  logic clk_sel;
  always_comb begin
    case (out_select)
      TXCK_OUT_HIGH: clk_sel = 1'b1;
      TXCK_OUT_PCS: clk_sel = clks.pcs_clk_path;
      TXCK_OUT_PMA: clk_sel = clks.pma_clk_path;
      TXCK_OUT_REF1: clk_sel = clks.pll_ref_clk_undivided;
      TXCK_OUT_REF2: clk_sel = clks.pll_ref_clk_halved;
      TXCK_OUT_PROG: clk_sel = clks.prog_divider_clk;
      default: clk_sel = 1'b0;
    endcase
  end
  // source for the programmable divider
  wire prog_sel = (prog_src == TXCK_SRC_AFTER_PI) ? src_s2[0] :
                  (prog_src == TXCK_SRC_BEFORE_PI) ? src_s2[1] : src_s2[2];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_clk_out <= 1'b0;
      prog_divider_src_clk <= 1'b0;
    end else begin
      tx_clk_out <= clk_sel;
      prog_divider_src_clk <= prog_sel;
    end
  end

  // ----------------------------------------------------------------
  // low-rate timer clock
  // ----------------------------------------------------------------
  // counts rising edges of the undivided reference; one enable every N edges
  logic ref_d;
  logic [5:0] lr_cnt;
  wire ref_rise = clks.pll_ref_clk_undivided & ~ref_d;
  wire lr_wrap = ref_rise & (lr_cnt + 6'h01 >= low_rate_clk_divider);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_d <= 1'b0;
      lr_cnt <= 6'h00;
      low_rate_clk_en <= 1'b0;
    end else begin
      ref_d <= clks.pll_ref_clk_undivided;
      low_rate_clk_en <= lr_wrap;
      if (lr_wrap) lr_cnt <= 6'h00;
      else if (ref_rise) lr_cnt <= lr_cnt + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // serial divider and rate change
  // ----------------------------------------------------------------
  logic [4:0] rate_div;
  always_comb begin
    case (tx_rate_select)
      3'h0: rate_div = div_reg;
      3'h1: rate_div = 5'h01;
      3'h2: rate_div = 5'h02;
      3'h3: rate_div = 5'h04;
      3'h4: rate_div = 5'h08;
      3'h5: rate_div = 5'h10;
      default: rate_div = div_reg;
    endcase
  end
  logic [2:0] rate_prev;
  logic [7:0] rate_cnt;
  wire rate_change = tx_rate_select != rate_prev;
  wire delay_done = rate_busy_reg & (rate_cnt == 8'h00);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_prev <= 3'h0;
      rate_busy_reg <= 1'b0;
      rate_cnt <= 8'h00;
      tx_rate_change_done <= 1'b0;
      phy_status <= 1'b0;
      div_out <= '{serial_div: `TXCK_RST_STATDIV, buffer_reset: 1'b0, reset_seq: 1'b0};
    end else begin
      rate_prev <= tx_rate_select;
      tx_rate_change_done <= delay_done;
      phy_status <= delay_done;
      if (rate_change) begin
        rate_busy_reg <= 1'b1;
        rate_cnt <= rate_transition_delay;
      end else if (delay_done) begin
        rate_busy_reg <= 1'b0;
      end else if (rate_busy_reg & low_rate_clk_en) begin
        rate_cnt <= rate_cnt - 8'h01;
      end
      // async mode tracks the rate at once; sync mode waits for the sequence
      if (tx_rate_async_mode | delay_done) div_out.serial_div <= rate_div;
      div_out.reset_seq <= ~tx_rate_async_mode & (rate_change | rate_busy_reg);
      div_out.buffer_reset <= buffer_reset_on_rate_change & (rate_change | rate_busy_reg);
    end
  end

  // ----------------------------------------------------------------
  // pi ppm controller
  // ----------------------------------------------------------------
  // select strap gates stepping, so an unused controller never steps the code
  wire ppm_active = ppm_ctrl_enable & ~ppm_ctrl_powerdown & ppm_select_sync;
  logic [3:0] mag;
  always_comb begin
    mag = pi_step_control[3:0];
    if (step_gray_select) begin
      mag[2] = mag[3] ^ mag[2];
      mag[1] = mag[2] ^ mag[1];
      mag[0] = mag[1] ^ mag[0];
    end
  end
  logic [2:0] intv_cnt;
  logic ovrd_msb_d;
  wire tick = ppm_active & (intv_cnt == pi_update_interval);
  wire ovrd_fall = ovrd_msb_d & ~pi_override_code[7];
  wire [6:0] step = {3'h0, mag};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intv_cnt <= 3'h0;
      ovrd_msb_d <= 1'b0;
      pi_code_reg <= 7'h00;
      pi_latched_reg <= 1'b0;
    end else begin
      ovrd_msb_d <= pi_override_code[7];
      if (!ppm_active || tick) intv_cnt <= 3'h0;
      else intv_cnt <= intv_cnt + 3'h1;
      if (pi_code_override_enable) begin
        // new override value registered on the high-then-low pulse of bit 7
        if (ovrd_fall) begin
          pi_code_reg <= pi_override_code[6:0];
          pi_latched_reg <= 1'b1;
        end
      end else if (tick) begin
        pi_code_reg <= pi_step_control[4] ? pi_code_reg + step : pi_code_reg - step;
      end
    end
  end
  assign pi_code = pi_code_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence rate_moved;
    tx_rate_select != rate_prev;
  endsequence
  done_single_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_rate_change_done |=> !tx_rate_change_done) else $error("done pulse too long");
  done_has_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_rate_change_done |-> $past(rate_busy_reg) && phy_status)
    else $error("done without rate change");
  rate_starts_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
    rate_moved |=> rate_busy_reg) else $error("rate change not tracked");
  pi_hold_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!ppm_active && !pi_code_override_enable) |=> $stable(pi_code))
    else $error("pi code moved while disabled");
  pi_down_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && !pi_code_override_enable && !pi_step_control[4]) |=>
    pi_code == $past(pi_code) - $past(step)) else $error("decrement wrong");
  interval_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
    intv_cnt <= pi_update_interval || !ppm_active) else $error("interval overrun");
  ovrd_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pi_code_override_enable && ovrd_fall) |=> pi_code == $past(pi_override_code[6:0]))
    else $error("override not latched");
  pd_no_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
    ppm_ctrl_powerdown |-> !tick) else $error("update while powered down");
  outsel_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    out_select == 3'h0 |=> tx_clk_out) else $error("static high not driven");
  statdiv_legal_a: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot(div_reg)) else $error("illegal static divider");
  lr_en_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
    lr_cnt < 6'h20) else $error("low-rate counter overrun");
  rate_div_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_rate_async_mode && tx_rate_select == 3'h3) |=> div_out.serial_div == 5'h04)
    else $error("rate code three not divide by four");
  buf_reset_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !buffer_reset_on_rate_change |=> !div_out.buffer_reset)
    else $error("buffer reset without option");
  prog_src_pll_a: assert property (@(posedge pclk) disable iff (!presetn)
    prog_src == TXCK_SRC_PLL |=> prog_divider_src_clk == $past(src_s2[2]))
    else $error("divider source not channel pll");
  lr_en_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    low_rate_clk_en |=> !low_rate_clk_en) else $error("low-rate enable too long");
endmodule

// ---- txck_user_model.sv ----
// far-side user logic model: clock sources and static user controls
// assumes the bench picks whether the ppm controller and the tx buffer are in use
`timescale 1ns/1ps
module txck_user_model import txck_pkg::*; (
  input wire logic ppm_in_use,
  input wire logic buffer_used,
  output txck_clks_s clk_pins,
  output logic after_interpolator_path,
  output logic before_interpolator_path,
  output logic channel_pll,
  output logic ppm_ctrl_select,
  output logic tx_delay_align_bypass
);
  // ------------------------------------------------------------
  // free-running sources, periods unrelated to the bus clock
  // ------------------------------------------------------------
  initial begin
    clk_pins = '0;
    after_interpolator_path = 1'b0;
    before_interpolator_path = 1'b0;
    channel_pll = 1'b0;
  end
  always #6.5 clk_pins.pll_ref_clk_undivided = ~clk_pins.pll_ref_clk_undivided;
  always #13 clk_pins.pll_ref_clk_halved = ~clk_pins.pll_ref_clk_halved;
  always #17 clk_pins.pcs_clk_path = ~clk_pins.pcs_clk_path;
  always #19 clk_pins.pma_clk_path = ~clk_pins.pma_clk_path;
  always #23 clk_pins.prog_divider_clk = ~clk_pins.prog_divider_clk;
  always #29 after_interpolator_path = ~after_interpolator_path;
  always #31 before_interpolator_path = ~before_interpolator_path;
  always #37 channel_pll = ~channel_pll;
  // ------------------------------------------------------------
  // user control levels
  // ------------------------------------------------------------
  assign ppm_ctrl_select = ppm_in_use;
  // bypass the alignment circuit only while the buffer is used
  assign tx_delay_align_bypass = buffer_used;
endmodule

// ---- test_tx_clock_out_and_pi_ppm_control.sv ----
// self-checking bench for the tx clock control block over apb
// assumes txck_top, txck_pkg and txck_user_model are compiled first
`timescale 1ns/1ps
`include "txck_params.svh"
module test_tx_clock_out_and_pi_ppm_control import txck_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  txck_clks_s clk_pins;
  logic after_pi, before_pi, chpll, ppm_sel, dly_bypass;
  logic ppm_in_use = 1'b1;
  logic buffer_used = 1'b1;
  logic tx_clk_out, prog_divider_src_clk, low_rate_clk_en, tx_rate_change_done, phy_status;
  txck_div_s div_out;
  txck_pi_code_t pi_code;
  int n_fail = 0;
  int check_count = 0;
  logic [31:0] rd;
  logic err, brst, rseq;
  logic [6:0] start_code, diff;
  int n_out, n_src, n_lr, n_ref, n_ticks;

  always #5 pclk = ~pclk;

  txck_user_model partner (.ppm_in_use(ppm_in_use), .buffer_used(buffer_used),
    .clk_pins(clk_pins), .after_interpolator_path(after_pi),
    .before_interpolator_path(before_pi), .channel_pll(chpll),
    .ppm_ctrl_select(ppm_sel), .tx_delay_align_bypass(dly_bypass));

  txck_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clk_pins(clk_pins), .after_interpolator_path(after_pi),
    .before_interpolator_path(before_pi), .channel_pll(chpll), .ppm_ctrl_select(ppm_sel),
    .tx_delay_align_bypass(dly_bypass), .tx_clk_out(tx_clk_out),
    .prog_divider_src_clk(prog_divider_src_clk), .low_rate_clk_en(low_rate_clk_en),
    .div_out(div_out), .tx_rate_change_done(tx_rate_change_done), .phy_status(phy_status),
    .pi_code(pi_code));

  // ------------------------------------------------------------
  // report helpers
  // ------------------------------------------------------------
  task automatic wrap_up();
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ------------------------------------------------------------
  // apb master: setup, then access until pready
  // ------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin
      n_fail++;
      wrap_up();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  // waits for the done pulse, noting side effects seen meanwhile
  task automatic wait_done(output logic bufrst, output logic rs);
    int i;
    bufrst = 1'b0;
    rs = 1'b0;
    for (i = 0; i < 2000; i++) begin
      @(posedge pclk);
      #1;
      bufrst |= div_out.buffer_reset;
      rs |= div_out.reset_seq;
      if (tx_rate_change_done === 1'b1) break;
    end
    if (i == 2000) begin
      n_fail++;
      wrap_up();
    end
    chk(phy_status, 1);
    @(posedge pclk);
    #1;
    chk(tx_rate_change_done, 0);
  endtask

  // counts changes of the clock outputs and low-rate enables over n cycles
  task automatic watch(input int n, output int n_o, output int n_s, output int n_l);
    logic lo, ls;
    n_o = 0;
    n_s = 0;
    n_l = 0;
    @(posedge pclk);
    #1;
    lo = tx_clk_out;
    ls = prog_divider_src_clk;
    repeat (n) begin
      @(posedge pclk);
      #1;
      n_o += (tx_clk_out !== lo);
      n_s += (prog_divider_src_clk !== ls);
      n_l += low_rate_clk_en;
      lo = tx_clk_out;
      ls = prog_divider_src_clk;
    end
  endtask

  function automatic logic [31:0] ctrl(input logic [4:0] dv, input logic br, input logic as);
    return {10'h0, 6'h04, 3'h0, dv, br, as, 6'h00};
  endfunction

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `TXCK_ADDR_CTRL, 0, rd, err);
    chk(rd, `TXCK_RST_CTRL);
    apb(1'b0, `TXCK_ADDR_RATE, 0, rd, err);
    chk(rd, `TXCK_RST_RATE);
    apb(1'b0, `TXCK_ADDR_PPM, 0, rd, err);
    chk(rd, `TXCK_RST_PPM);
    apb(1'b0, 12'h020, 0, rd, err);
    chk(err, 1);
    wr(`TXCK_ADDR_CTRL, ctrl(5'h01, 1'b0, 1'b0));
    repeat (6) @(posedge pclk);
    chk(tx_clk_out, 1);
    for (int r = 1; r <= 5; r++) begin
      wr(`TXCK_ADDR_RATE, 32'h0100 | r);
      wait_done(brst, rseq);
      chk(div_out.serial_div, 1 << (r - 1));
      chk(rseq, 1);
      chk(brst, 0);
    end
    wr(`TXCK_ADDR_CTRL, ctrl(5'h08, 1'b1, 1'b0));
    wr(`TXCK_ADDR_RATE, 32'h0100);
    wait_done(brst, rseq);
    chk(div_out.serial_div, 8);
    chk(brst, 1);
    wr(`TXCK_ADDR_CTRL, ctrl(5'h03, 1'b1, 1'b0));
    apb(1'b0, `TXCK_ADDR_CTRL, 0, rd, err);
    chk(rd, ctrl(5'h08, 1'b1, 1'b0));
    wr(`TXCK_ADDR_CTRL, ctrl(5'h08, 1'b0, 1'b1));
    wr(`TXCK_ADDR_RATE, 32'h0103);
    repeat (4) @(posedge pclk);
    chk(div_out.serial_div, 4);
    // every listed source reaches the outputs; a reserved code drives no clock
    for (int s = 1; s <= 7; s++) begin
      if (s != 6) begin
        wr(`TXCK_ADDR_CTRL, ctrl(5'h08, 1'b0, 1'b1) | s | ((s % 3) << 4));
        watch(100, n_out, n_src, n_lr);
        chk(n_out != 0, s != 7);
        chk(n_src != 0, 1);
      end
    end
    // divide by one gives far more timer enables than divide by thirty-two
    wr(`TXCK_ADDR_CTRL, 32'h0001_0800);
    watch(400, n_out, n_src, n_ref);
    wr(`TXCK_ADDR_CTRL, 32'h0020_0800);
    watch(400, n_out, n_src, n_lr);
    chk(n_lr != 0 && n_ref > 8 * n_lr, 1);
    wr(`TXCK_ADDR_CTRL, 32'h0000_0800);
    apb(1'b0, `TXCK_ADDR_CTRL, 0, rd, err);
    chk(rd, 32'h0020_0800);
    wr(`TXCK_ADDR_CTRL, ctrl(5'h08, 1'b0, 1'b1));
    // override latches only on the falling top bit
    wr(`TXCK_ADDR_PPM, 32'h0000_0010);
    wr(`TXCK_ADDR_OVRD, 32'h0000_01D5);
    wr(`TXCK_ADDR_OVRD, 32'h0000_0155);
    repeat (2) @(posedge pclk);
    chk(pi_code, 7'h55);
    apb(1'b0, `TXCK_ADDR_STAT, 0, rd, err);
    chk(rd[6:0], 7'h55);
    wr(`TXCK_ADDR_OVRD, 32'h0000_0055);
    repeat (20) @(posedge pclk);
    chk(pi_code, 7'h55);
    // up by 3, down by 5, gray 0010 (binary 3) up; same window, so same tick count
    for (int i = 0; i < 3; i++) begin
      start_code = pi_code;
      wr(`TXCK_ADDR_PPM, (i == 0) ? 32'h1311 : (i == 1) ? 32'h0511 : 32'h1215);
      repeat (20) @(posedge pclk);
      wr(`TXCK_ADDR_PPM, 32'h0010);
      diff = (i == 1) ? start_code - pi_code : pi_code - start_code;
      if (i == 0) n_ticks = diff / 3;
      chk(diff, ((i == 1) ? 5 : 3) * n_ticks);
    end
    chk(n_ticks != 0, 1);
    // straps are seen through the status word; select low stops stepping
    apb(1'b0, `TXCK_ADDR_STAT, 0, rd, err);
    chk(rd[11:10], 2'b11);
    ppm_in_use <= 1'b0;
    buffer_used <= 1'b0;
    start_code = pi_code;
    wr(`TXCK_ADDR_PPM, 32'h1311);
    repeat (20) @(posedge pclk);
    chk(pi_code, start_code);
    apb(1'b0, `TXCK_ADDR_STAT, 0, rd, err);
    chk(rd[11:10], 2'b00);
    wr(`TXCK_ADDR_PPM, 32'h0010);
    ppm_in_use <= 1'b1;
    buffer_used <= 1'b1;
    start_code = pi_code;
    wr(`TXCK_ADDR_PPM, 32'h1313);
    repeat (20) @(posedge pclk);
    chk(pi_code, start_code);
    wrap_up();
  end
endmodule
